// ### drive_fieldbus_aux_words.sv
// Auxiliary command, auxiliary condition and first fault process words
// exchanged with a fieldbus master, and the drive controls they steer.
// Assumes the fieldbus interface and drive logic share core_clk.

`timescale 1ns/1ns

module drive_fieldbus_aux_words
  import drive_aux_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Fieldbus process data
  input wire logic pd_cmd_valid,
  input wire logic [15:0] pd_cmd_data,
  input wire logic pd_refresh,
  output logic [15:0] aux_command_word,
  output logic [15:0] aux_condition_word,
  output logic [15:0] first_fault_flags,
  // Drive context
  input wire logic [1:0] main_inch_req,
  input wire logic control_place_fieldbus,
  input wire logic [15:0] ramp_out_speed,
  input wire logic [15:0] zero_speed_threshold,
  input wire out_source_t first_output_source_param,
  input wire out_source_t second_output_source_param,
  input wire out_source_t third_output_source_param,
  input wire drive_cond_t drive_cond,
  input wire fault_in_t fault_in,
  // Drive controls
  output ctrl_out_t ctrl
);

  // Selector points at this word's bit
  function automatic logic src_match(input out_source_t s,
                                     input logic [3:0] idx);
    src_match = (s.param_id == SRC_PARAM_ID) && (s.bit_idx == idx);
  endfunction

  // Command word
  logic [15:0] cmd_ff;
  logic [15:0] nxt_cmd;
  logic [15:0] cmd_eff;

  always_comb begin
    nxt_cmd = cmd_ff;
    if (pd_cmd_valid) begin
      nxt_cmd = pd_cmd_data;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cmd_ff <= CMD_RESET;
    end else begin
      cmd_ff <= nxt_cmd;
    end
  end

  // Free bits are kept for readback but steer nothing
  assign cmd_eff = cmd_ff & CMD_USED_MASK; // [R19]
  assign aux_command_word = cmd_ff;

  // Edge pulses: logger restart, logger trigger, charging done
  logic [EVT_N-1:0] evt_level;
  logic [EVT_N-1:0] evt_pulse;

  assign evt_level[EVT_RESTART] = cmd_eff[CMD_LOG_RESTART];
  assign evt_level[EVT_TRIGGER] = cmd_eff[CMD_LOG_TRIGGER];
  assign evt_level[EVT_CHARGE] = drive_cond.dc_charge_ok;

  genvar gi;
  generate
    for (gi = 0; gi < EVT_N; gi++) begin : g_evt
      rise_pulse u_rise (
        .core_clk(core_clk),
        .reset(reset),
        .level(evt_level[gi]),
        .pulse(evt_pulse[gi])
      );
    end
  endgenerate

  // Charging-done pulse held until a refresh in a later cycle carries it out
  logic charge_pend_ff;
  logic nxt_charge_pend;

  always_comb begin
    nxt_charge_pend = charge_pend_ff;
    if (pd_refresh) begin
      nxt_charge_pend = 1'b0;
    end
    if (evt_pulse[EVT_CHARGE]) begin
      nxt_charge_pend = 1'b1; // [R14]
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      charge_pend_ff <= 1'b0;
    end else begin
      charge_pend_ff <= nxt_charge_pend;
    end
  end

  // Condition and fault words, sampled on each refresh
  logic [15:0] cond_ff;
  logic [15:0] nxt_cond;
  logic [15:0] cond_live;
  logic [15:0] fault_ff;
  logic [15:0] nxt_fault;
  logic [15:0] fault_live;

  always_comb begin
    cond_live = COND_RESET;
    cond_live[0] = drive_cond.logger_triggered; // [R11]
    cond_live[1] = drive_cond.speed_out_of_window; // [R11]
    cond_live[2] = drive_cond.torque_limit; // [R12]
    cond_live[3] = drive_cond.volt_ctrl; // [R12]
    cond_live[4] = drive_cond.reverse; // [R13]
    cond_live[5] = drive_cond.io_ctrl; // [R13]
    cond_live[6] = drive_cond.fan_on; // [R13]
    cond_live[7] = drive_cond.brake_lift; // [R13]
    cond_live[8] = charge_pend_ff | evt_pulse[EVT_CHARGE]; // [R14]
    cond_live[9] = drive_cond.dc_charge_ok; // [R14]
    cond_live[10] = drive_cond.torque_ctrl; // [R15]
    cond_live[11] = drive_cond.zero_speed; // [R15]
    cond_live = cond_live & COND_USED_MASK; // [R19]
  end

  always_comb begin
    fault_live = FAULT_RESET;
    fault_live[0] = fault_in.overcurrent; // [R16]
    fault_live[1] = fault_in.overvoltage; // [R16]
    fault_live[2] = fault_in.undervoltage; // [R16]
    fault_live[3] = fault_in.stall; // [R16]
    fault_live[4] = fault_in.earth; // [R16]
    fault_live[5] = fault_in.underload; // [R16]
    fault_live[6] = fault_in.unit_overtemp; // [R16]
    fault_live[7] = fault_in.motor_thermistor | fault_in.motor_rtd |
                    fault_in.motor_model; // [R17]
    fault_live[8] = fault_in.input_phase_loss; // [R16]
    fault_live[9] = fault_in.brake_resistor; // [R16]
    fault_live[10] = fault_in.option_change; // [R18]
    fault_live[11] = fault_in.keypad_comm; // [R18]
    fault_live[12] = fault_in.fieldbus_comm; // [R18]
    fault_live[13] = fault_in.follower_comm; // [R18]
    fault_live[14] = fault_in.slot_comm; // [R18]
    fault_live[15] = fault_in.analogue_in; // [R18]
  end

  always_comb begin
    nxt_cond = cond_ff;
    nxt_fault = fault_ff;
    if (pd_refresh) begin
      nxt_cond = cond_live; // [R20]
      nxt_fault = fault_live; // [R20]
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cond_ff <= COND_RESET;
      fault_ff <= FAULT_RESET;
    end else begin
      cond_ff <= nxt_cond;
      fault_ff <= nxt_fault;
    end
  end

  assign aux_condition_word = cond_ff;
  assign first_fault_flags = fault_ff;

  // Drive controls, registered
  ctrl_out_t ctrl_ff;
  ctrl_out_t nxt_ctrl;

  always_comb begin
    nxt_ctrl = '0;
    nxt_ctrl.logger_restart = evt_pulse[EVT_RESTART]; // [R1]
    nxt_ctrl.logger_trigger = evt_pulse[EVT_TRIGGER]; // [R1]
    nxt_ctrl.ramp_bypass = cmd_eff[CMD_RAMP_BYPASS]; // [R2]
    nxt_ctrl.ref_from_io = cmd_eff[CMD_REF_FROM_IO] &
                           control_place_fieldbus; // [R3]
    nxt_ctrl.dc_brake_on = cmd_eff[CMD_DC_BRAKE] &
                           (ramp_out_speed < zero_speed_threshold); // [R4]
    nxt_ctrl.mech_brake = cmd_eff[CMD_MECH_BRAKE]; // [R5]
    nxt_ctrl.pos_clear = cmd_eff[CMD_POS_CLEAR]; // [R6]
    nxt_ctrl.inch_fwd = cmd_eff[CMD_INCH_EN] &
                        main_inch_req[MAIN_INCH_FWD]; // [R7]
    nxt_ctrl.inch_rev = cmd_eff[CMD_INCH_EN] &
                        main_inch_req[MAIN_INCH_REV]; // [R7]
    nxt_ctrl.dig_out_one = cmd_eff[CMD_DOUT_ONE] &
      src_match(first_output_source_param, SRC_BIT_DOUT_ONE); // [R8]
    nxt_ctrl.relay_out_one = cmd_eff[CMD_RELAY_ONE] &
      src_match(second_output_source_param, SRC_BIT_RELAY_ONE); // [R9]
    nxt_ctrl.relay_out_two = cmd_eff[CMD_RELAY_TWO] &
      src_match(third_output_source_param, SRC_BIT_RELAY_TWO); // [R10]
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign ctrl = ctrl_ff;

  // Checks
  AST_LOG_RESTART: assert property (@(posedge core_clk) // [R1]
    disable iff (reset)
    pd_cmd_valid && pd_cmd_data[CMD_LOG_RESTART] && !cmd_ff[CMD_LOG_RESTART]
    |-> ##2 ctrl.logger_restart ##1 !ctrl.logger_restart)
    else $error("logger restart pulse wrong");

  AST_RAMP_BYPASS: assert property (@(posedge core_clk) // [R2]
    disable iff (reset)
    ##1 ctrl.ramp_bypass == $past(cmd_ff[CMD_RAMP_BYPASS]))
    else $error("ramp bypass not following command");

  AST_REF_IO: assert property (@(posedge core_clk) // [R3]
    disable iff (reset)
    pd_cmd_valid && pd_cmd_data[CMD_REF_FROM_IO] ##1
    (control_place_fieldbus && !pd_cmd_valid) |=> ctrl.ref_from_io)
    else $error("reference source not switched to local I/O");

  AST_DC_BRAKE: assert property (@(posedge core_clk) // [R4]
    disable iff (reset)
    ramp_out_speed >= zero_speed_threshold |=> !ctrl.dc_brake_on)
    else $error("DC brake above zero-speed threshold");

  AST_MECH_BRAKE: assert property (@(posedge core_clk) // [R5]
    disable iff (reset)
    pd_cmd_valid |-> ##2 ctrl.mech_brake ==
    $past(pd_cmd_data[CMD_MECH_BRAKE], 2))
    else $error("brake control not following command");

  AST_POS_CLEAR: assert property (@(posedge core_clk) // [R6]
    disable iff (reset)
    pd_cmd_valid && pd_cmd_data[CMD_POS_CLEAR] |-> ##2 ctrl.pos_clear)
    else $error("position clear missing");

  AST_POS_RELEASE: assert property (@(posedge core_clk) // [R6]
    disable iff (reset)
    !cmd_ff[CMD_POS_CLEAR] |=> !ctrl.pos_clear)
    else $error("position clear held without command bit");

  AST_INCH: assert property (@(posedge core_clk) // [R7]
    disable iff (reset)
    !cmd_ff[CMD_INCH_EN] |=> !ctrl.inch_fwd && !ctrl.inch_rev)
    else $error("inching while disabled");

  AST_INCH_ON: assert property (@(posedge core_clk) // [R7]
    disable iff (reset)
    cmd_ff[CMD_INCH_EN] && main_inch_req == 2'b01
    |=> ctrl.inch_fwd && !ctrl.inch_rev)
    else $error("forward inching not passed through");

  AST_DOUT: assert property (@(posedge core_clk) // [R8]
    disable iff (reset)
    first_output_source_param.bit_idx != SRC_BIT_DOUT_ONE
    |=> !ctrl.dig_out_one)
    else $error("digital output driven without selection");

  AST_DOUT_ON: assert property (@(posedge core_clk) // [R8]
    disable iff (reset)
    cmd_ff[CMD_DOUT_ONE] &&
    first_output_source_param.param_id == SRC_PARAM_ID &&
    first_output_source_param.bit_idx == SRC_BIT_DOUT_ONE
    |=> ctrl.dig_out_one)
    else $error("selected digital output not driven");

  AST_RELAYS: assert property (@(posedge core_clk) // [R9] [R10]
    disable iff (reset)
    !cmd_ff[CMD_RELAY_ONE] && !cmd_ff[CMD_RELAY_TWO]
    |=> !ctrl.relay_out_one && !ctrl.relay_out_two)
    else $error("relay driven without command bit");

  AST_CHARGE_PULSE: assert property (@(posedge core_clk) // [R14]
    disable iff (reset)
    $rose(drive_cond.dc_charge_ok) ##1 pd_refresh
    |=> aux_condition_word[8])
    else $error("charging pulse lost before refresh");

  AST_COND_CAPTURE: assert property (@(posedge core_clk) // [R13] [R14]
    disable iff (reset)
    pd_refresh |=> aux_condition_word[4] == $past(drive_cond.reverse) &&
    aux_condition_word[9] == $past(drive_cond.dc_charge_ok))
    else $error("condition word not sampled at refresh");

  AST_RESERVED: assert property (@(posedge core_clk) // [R15] [R19]
    disable iff (reset)
    aux_condition_word[15:12] == 4'h0)
    else $error("reserved status bits set");

  AST_FAULT_CAPTURE: assert property (@(posedge core_clk) // [R16] [R18]
    disable iff (reset)
    pd_refresh |=> first_fault_flags[4] == $past(fault_in.earth) &&
    first_fault_flags[12] == $past(fault_in.fieldbus_comm))
    else $error("fault word not sampled at refresh");

  AST_MOTOR_TEMP: assert property (@(posedge core_clk) // [R17]
    disable iff (reset)
    pd_refresh && fault_in.motor_rtd |=> first_fault_flags[7])
    else $error("motor overtemperature not flagged");

  AST_FAULT_HOLD: assert property (@(posedge core_clk) // [R20]
    disable iff (reset)
    !pd_refresh |=> $stable(first_fault_flags) &&
    $stable(aux_condition_word))
    else $error("words changed without refresh");

endmodule

// ### drive_aux_pkg.sv
// Constants, field layouts and carriers for the fieldbus auxiliary words,
// plus the rising-edge pulse cell that the word bank instantiates.
// Assumes one core clock; all drive-side inputs come from that domain.
//
// Overview of operation
// R1 - Command bits 0/1 restart and trigger logger
// R2 - Command bit 2 bypasses the ramp generator
// R3 - Bit 3 takes reference from I/O if fieldbus is control place
// R4 - Bit 4 brakes DC below zero-speed threshold
// R5 - Command bit 7 drives the mechanical brake
// R6 - Bit 9 clears shaft position and rounds
// R7 - Bit 12 gates inching from main word
// R8 - Bit 13 drives digital output one if selected
// R9 - Bit 14 drives relay one if selected
// R10 - Bit 15 drives relay two if selected
// R11 - Status bits 0/1: logger triggered, window fault
// R12 - Status bits 2/3: limits, voltage controller active
// R13 - Status bits 4-7: reverse, I/O, fan, brake
// R14 - Status bit 8 pulse, bit 9 charging level
// R15 - Status bits 10/11 torque, zero; rest reserved
// R16 - Fault bits 0-6, 8, 9 drive faults
// R17 - Fault bit 7: any motor overtemperature source
// R18 - Fault bits 10-15 communication and input faults
// R19 - Free command bits ignored, reserved read zero
// R20 - Flags follow conditions, refreshed each exchange

`timescale 1ns/1ns

package drive_aux_pkg;

  localparam int WORD_W = 16;

  // Command word bit positions
  localparam int CMD_LOG_RESTART = 0;
  localparam int CMD_LOG_TRIGGER = 1;
  localparam int CMD_RAMP_BYPASS = 2;
  localparam int CMD_REF_FROM_IO = 3;
  localparam int CMD_DC_BRAKE = 4;
  localparam int CMD_MECH_BRAKE = 7;
  localparam int CMD_POS_CLEAR = 9;
  localparam int CMD_INCH_EN = 12;
  localparam int CMD_DOUT_ONE = 13;
  localparam int CMD_RELAY_ONE = 14;
  localparam int CMD_RELAY_TWO = 15;

  // Main command word inching bits
  localparam int MAIN_INCH_FWD = 0;
  localparam int MAIN_INCH_REV = 1;

  // Values after reset
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] COND_RESET = 16'h0000;
  localparam logic [15:0] FAULT_RESET = 16'h0000;

  // Bits with a function in the command and condition words; free command bits stay stored only
  localparam logic [15:0] CMD_USED_MASK = 16'hf29f;
  localparam logic [15:0] COND_USED_MASK = 16'h0fff;

  // Output source selector: parameter 1161, bits 13..15
  localparam logic [15:0] SRC_PARAM_ID = 16'h0489;
  localparam logic [3:0] SRC_BIT_DOUT_ONE = 4'hd;
  localparam logic [3:0] SRC_BIT_RELAY_ONE = 4'he;
  localparam logic [3:0] SRC_BIT_RELAY_TWO = 4'hf;

  // Edge pulse channels
  localparam int EVT_N = 3;
  localparam int EVT_RESTART = 0;
  localparam int EVT_TRIGGER = 1;
  localparam int EVT_CHARGE = 2;

  typedef struct packed {
    logic [15:0] param_id;
    logic [3:0] bit_idx;
  } out_source_t;

  typedef struct packed {
    logic logger_triggered;
    logic speed_out_of_window;
    logic torque_limit;
    logic volt_ctrl;
    logic reverse;
    logic io_ctrl;
    logic fan_on;
    logic brake_lift;
    logic dc_charge_ok;
    logic torque_ctrl;
    logic zero_speed;
  } drive_cond_t;

  typedef struct packed {
    logic overcurrent;
    logic overvoltage;
    logic undervoltage;
    logic stall;
    logic earth;
    logic underload;
    logic unit_overtemp;
    logic motor_thermistor;
    logic motor_rtd;
    logic motor_model;
    logic input_phase_loss;
    logic brake_resistor;
    logic option_change;
    logic keypad_comm;
    logic fieldbus_comm;
    logic follower_comm;
    logic slot_comm;
    logic analogue_in;
  } fault_in_t;

  typedef struct packed {
    logic logger_restart;
    logic logger_trigger;
    logic ramp_bypass;
    logic ref_from_io;
    logic dc_brake_on;
    logic mech_brake;
    logic pos_clear;
    logic inch_fwd;
    logic inch_rev;
    logic dig_out_one;
    logic relay_out_one;
    logic relay_out_two;
  } ctrl_out_t;

endpackage

// One-cycle pulse on each rising edge of a same-clock level
module rise_pulse (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Level in, pulse out
  input wire logic level,
  output logic pulse
);
  logic prev_ff;
  logic nxt_prev;

  always_comb begin
    nxt_prev = level;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  assign pulse = level & ~prev_ff;
endmodule

// ### fieldbus_master_model.sv
// Fieldbus master model: writes the auxiliary command word and strobes
// process data refresh. Tasks are entered just after a core_clk edge.
`timescale 1ns/1ns

module fieldbus_master_model (
  // Clock
  input wire logic core_clk,
  // Process data strobes
  output logic pd_cmd_valid,
  output logic [15:0] pd_cmd_data,
  output logic pd_refresh
);
  initial begin
    pd_cmd_valid = 1'b0;
    pd_cmd_data = 16'h0000;
    pd_refresh = 1'b0;
  end

  // Idle data shows the inverse of the last word, never a stale copy
  task write_cmd(input logic [15:0] d);
    pd_cmd_valid = 1'b1;
    pd_cmd_data = d;
    @(posedge core_clk);
    #1;
    pd_cmd_valid = 1'b0;
    pd_cmd_data = ~d;
  endtask

  task refresh();
    pd_refresh = 1'b1;
    @(posedge core_clk);
    #1;
    pd_refresh = 1'b0;
  endtask
endmodule

// ### drive_fieldbus_aux_words_tb_top.sv
// Self-checking bench for the auxiliary word bank.
// Assumes the master model drives the strobes and the bench the context.
`timescale 1ns/1ns

module drive_fieldbus_aux_words_tb_top;
  import drive_aux_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic pd_cmd_valid;
  logic pd_refresh;
  logic [15:0] pd_cmd_data;
  logic [15:0] aux_command_word;
  logic [15:0] aux_condition_word;
  logic [15:0] first_fault_flags;
  logic [1:0] main_inch_req = 2'b00;
  logic control_place_fieldbus = 1'b0;
  logic [15:0] ramp_out_speed = 16'h0000;
  logic [15:0] zero_speed_threshold = 16'h0000;
  out_source_t src1 = '0;
  out_source_t src2 = '0;
  out_source_t src3 = '0;
  drive_cond_t drive_cond = '0;
  fault_in_t fault_in = '0;
  ctrl_out_t ctrl;
  int failures = 0;
  int n_compared = 0;
  logic [31:0] lfsr = 32'h4cc7_e924;
  logic [15:0] prev_cmd = 16'h0000;
  logic pend = 1'b0;
  logic [15:0] corner [5] = '{16'hffff, 16'h0000, 16'h0d60, 16'h0003,
                              16'h0003};

  always #2 core_clk = ~core_clk;

  fieldbus_master_model i_master (
    .core_clk(core_clk),
    .pd_cmd_valid(pd_cmd_valid),
    .pd_cmd_data(pd_cmd_data),
    .pd_refresh(pd_refresh)
  );

  drive_fieldbus_aux_words i_dut (
    .core_clk(core_clk),
    .reset(reset),
    .pd_cmd_valid(pd_cmd_valid),
    .pd_cmd_data(pd_cmd_data),
    .pd_refresh(pd_refresh),
    .aux_command_word(aux_command_word),
    .aux_condition_word(aux_condition_word),
    .first_fault_flags(first_fault_flags),
    .main_inch_req(main_inch_req),
    .control_place_fieldbus(control_place_fieldbus),
    .ramp_out_speed(ramp_out_speed),
    .zero_speed_threshold(zero_speed_threshold),
    .first_output_source_param(src1),
    .second_output_source_param(src2),
    .third_output_source_param(src3),
    .drive_cond(drive_cond),
    .fault_in(fault_in),
    .ctrl(ctrl)
  );

  function automatic logic [31:0] next_rand();
    repeat (7) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] exp_cond(input drive_cond_t c,
                                           input logic p);
    return {4'h0, c.zero_speed, c.torque_ctrl, c.dc_charge_ok, p,
            c.brake_lift, c.fan_on, c.io_ctrl, c.reverse, c.volt_ctrl,
            c.torque_limit, c.speed_out_of_window, c.logger_triggered};
  endfunction

  function automatic logic [15:0] exp_fault(input fault_in_t f);
    return {f.analogue_in, f.slot_comm, f.follower_comm, f.fieldbus_comm,
            f.keypad_comm, f.option_change, f.brake_resistor,
            f.input_phase_loss, f.motor_thermistor | f.motor_rtd |
            f.motor_model, f.unit_overtemp, f.underload, f.earth, f.stall,
            f.undervoltage, f.overvoltage, f.overcurrent};
  endfunction

  function automatic ctrl_out_t exp_ctrl(input logic [15:0] c,
                                         input logic [15:0] p);
    ctrl_out_t e;
    e.logger_restart = c[0] & ~p[0];
    e.logger_trigger = c[1] & ~p[1];
    e.ramp_bypass = c[2];
    e.ref_from_io = c[3] & control_place_fieldbus;
    e.dc_brake_on = c[4] & (ramp_out_speed < zero_speed_threshold);
    e.mech_brake = c[7];
    e.pos_clear = c[9];
    e.inch_fwd = c[12] & main_inch_req[0];
    e.inch_rev = c[12] & main_inch_req[1];
    e.dig_out_one = c[13] & (src1 == {SRC_PARAM_ID, SRC_BIT_DOUT_ONE});
    e.relay_out_one = c[14] & (src2 == {SRC_PARAM_ID, SRC_BIT_RELAY_ONE});
    e.relay_out_two = c[15] & (src3 == {SRC_PARAM_ID, SRC_BIT_RELAY_TWO});
    return e;
  endfunction

  // Selectors hit the matching value, a wrong bit, or noise
  task pick_src(output out_source_t s, input logic [3:0] idx);
    logic [31:0] r;
    r = next_rand();
    s = r[0] ? {SRC_PARAM_ID, r[1] ? idx : r[5:2]} : r[24:5];
  endtask

  task apply_ctx();
    logic [31:0] r;
    logic [31:0] r2;
    r = next_rand();
    if (!drive_cond.dc_charge_ok && r[2]) pend = 1'b1;
    drive_cond = r[10:0];
    r = next_rand();
    r2 = next_rand();
    fault_in = r[17:0] & r2[17:0];
    main_inch_req = r2[31:30];
    control_place_fieldbus = r2[29];
    r = next_rand();
    ramp_out_speed = r[15:0];
    zero_speed_threshold = r[31:16];
    pick_src(src1, SRC_BIT_DOUT_ONE);
    pick_src(src2, SRC_BIT_RELAY_ONE);
    pick_src(src3, SRC_BIT_RELAY_TWO);
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task refresh_check();
    logic [15:0] ec;
    ec = exp_cond(drive_cond, pend);
    i_master.refresh();
    check(aux_condition_word, ec);
    pend = 1'b0;
    check(first_fault_flags, exp_fault(fault_in));
  endtask

  task cmd_check(input logic [15:0] c);
    ctrl_out_t ec;
    ec = exp_ctrl(c, prev_cmd);
    i_master.write_cmd(c);
    check(aux_command_word, c);
    @(posedge core_clk);
    #1;
    check({9'h0, ctrl[11:5]}, {9'h0, ec[11:5]});
    check({11'h0, ctrl[4:0]}, {11'h0, ec[4:0]});
    @(posedge core_clk);
    #1;
    check({4'h0, ctrl}, {4'h0, exp_ctrl(c, c)});
    prev_cmd = c;
  endtask

  task close_out();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    close_out();
  end

  initial begin
    logic [31:0] r;
    repeat (3) @(posedge core_clk);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 5; i++) begin
      apply_ctx();
      cmd_check(corner[i]);
      refresh_check();
    end
    for (int i = 0; i < 60; i++) begin
      apply_ctx();
      refresh_check();
      r = next_rand();
      cmd_check(r[15:0]);
    end
    // Charging pulse shows at one refresh only, level stays
    drive_cond.dc_charge_ok = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    refresh_check();
    drive_cond.dc_charge_ok = 1'b1;
    pend = 1'b1;
    @(posedge core_clk);
    #1;
    refresh_check();
    @(posedge core_clk);
    #1;
    refresh_check();
    // Reset in mid-run clears every word and control
    reset = 1'b1;
    @(posedge core_clk);
    #1;
    check(aux_command_word | aux_condition_word, 16'h0000);
    check(first_fault_flags, 16'h0000);
    reset = 1'b0;
    @(posedge core_clk);
    #1;
    check({4'h0, ctrl} | aux_command_word, 16'h0000);
    check(first_fault_flags, 16'h0000);
    close_out();
  end
endmodule
